/* File: rtl/ivr_map.svh */
// Offsets, field positions, reset values and fixed addresses of the vector resolver.
// Assumes inclusion by the resolver module only.
`ifndef IVR_MAP_SVH
`define IVR_MAP_SVH

// Fixed vector entries, each the low byte address of a four-byte entry.
`define IVR_FIX_UND 20'hfffdc
`define IVR_FIX_INTO 20'hfffe0
`define IVR_FIX_BRK 20'hfffe4
`define IVR_FIX_AMATCH 20'hfffe8
`define IVR_FIX_SSTEP 20'hfffec
`define IVR_FIX_WDT 20'hffff0
`define IVR_FIX_DBC 20'hffff4
`define IVR_FIX_NMI 20'hffff8
`define IVR_FIX_RESET 20'hffffc

// Variable table: 64 entries of four bytes after the table base.
`define IVR_NUM_SRC 64
`define IVR_BRK_NUM 6'h00
`define IVR_MASKABLE_SET 64'h001fffff_99fffdf2
`define IVR_FIRST_SOFT_ONLY 6'h35
`define IVR_FIRST_NO_STACK_SWAP 6'h20
`define IVR_ERASED_BYTE 8'hff

// Wishbone word offsets (byte address bits 9:2).
`define IVR_REG_TABLE_BASE 8'h00
`define IVR_REG_FLAG_WORD 8'h01
`define IVR_REG_SPECIAL 8'h02
`define IVR_REG_STATUS 8'h03
`define IVR_REG_SAVED_FLAG 8'h04
`define IVR_REG_CTL_FIRST 8'h40

// Per-source control register fields.
`define IVR_CTL_LVL_LSB 0
`define IVR_CTL_REQ_BIT 3

// Processor flag word fields.
`define IVR_FLG_D_BIT 2
`define IVR_FLG_I_BIT 6
`define IVR_FLG_U_BIT 7
`define IVR_FLG_IPL_LSB 12
`define IVR_FLG_RESET 16'h0000
`define IVR_BASE_RESET 20'h00000
`define IVR_HW_LEVEL 3'h7

// Special source pending bits.
`define IVR_SP_AMATCH 0
`define IVR_SP_SSTEP 1
`define IVR_SP_WDT 2
`define IVR_SP_DBC 3
`define IVR_SP_NMI 4
`define IVR_SP_RESET 5
`define IVR_SP_RESET_VAL 6'h20

`endif

/* File: rtl/ivr_pkg.sv */
// Types shared by the interrupt vector resolver and its surroundings.
// Assumes the map header for field values.
package ivr_pkg;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_FETCH = 1'b1
    } state_t;

    typedef enum logic [3:0] {
        SRC_RESET = 4'h0,
        SRC_NMI = 4'h1,
        SRC_DBC = 4'h2,
        SRC_WDT = 4'h3,
        SRC_SSTEP = 4'h4,
        SRC_AMATCH = 4'h5,
        SRC_UND = 4'h6,
        SRC_INTO = 4'h7,
        SRC_BRK = 4'h8,
        SRC_SWINT = 4'h9,
        SRC_PERIPH = 4'ha
    } src_t;

    typedef enum logic [1:0] {
        TRAP_UND = 2'h0,
        TRAP_INTO = 2'h1,
        TRAP_BRK = 2'h2,
        TRAP_INT = 2'h3
    } trap_kind_t;

    typedef struct packed {
        logic valid;
        trap_kind_t kind;
        logic [5:0] number;
    } trap_t;

    typedef struct packed {
        logic req;
        logic [2:0] lvl;
    } ctl_t;

    typedef struct packed {
        logic valid;
        logic [19:0] addr;
        src_t kind;
        logic [5:0] number;
        logic [2:0] level;
        logic [15:0] saved_flag;
    } branch_t;

    typedef struct packed {
        logic rd;
        logic [19:0] addr;
    } vec_req_t;

endpackage

/* File: rtl/interrupt_vector_resolver.sv */
// Interrupt vector resolver: arbitrates sources, fetches the vector and hands a branch to the CPU.
// Assumes a byte-wide vector memory port, a Wishbone classic master and the CPU on clk_i.
//
// Local design decisions: the register offsets and register access over Wishbone.
`timescale 1ns/1ns
`include "ivr_map.svh"

module interrupt_vector_resolver (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [63:0] src_evt_i,
    input wire logic address_match_i,
    input wire logic single_step_i,
    input wire logic watchdog_i,
    input wire logic debugger_break_source_i,
    input wire logic nmi_pin_i,
    input wire ivr_pkg::trap_t trap_i,
    input wire logic cpu_ready_i,
    output ivr_pkg::vec_req_t vec_req_o,
    input wire logic [7:0] vec_data_i,
    input wire logic vec_ack_i,
    output ivr_pkg::branch_t branch_o
);

    typedef struct packed {
        ivr_pkg::state_t st;
        ivr_pkg::ctl_t [63:0] ctl;
        logic [19:0] vector_table_base;
        logic [15:0] processor_flag_word;
        logic [15:0] saved_flag;
        logic am_en;
        logic [5:0] spec_pend;
        ivr_pkg::trap_t trap;
        ivr_pkg::src_t cur_kind;
        logic [5:0] cur_num;
        logic [2:0] cur_lvl;
        logic redir;
        logic [1:0] cnt;
        logic [19:0] acc;
        ivr_pkg::vec_req_t vec;
        ivr_pkg::branch_t branch;
        logic ack;
        logic [31:0] dat;
    } state_all_t;

    state_all_t s_q;
    state_all_t s_d;

    // Byte-lane merge of a bus write into an existing word.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wr,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = wr[8*b +: 8];
            end
        end
        return r;
    endfunction

    // Variable table entry address.
    function automatic logic [19:0] var_entry(input logic [19:0] base, input logic [5:0] num);
        return base + {12'h000, num, 2'b00};
    endfunction

    function automatic logic [19:0] fixed_entry(input ivr_pkg::src_t k);
        logic [19:0] a;
        a = `IVR_FIX_RESET;
        unique case (k)
            ivr_pkg::SRC_UND: a = `IVR_FIX_UND;
            ivr_pkg::SRC_INTO: a = `IVR_FIX_INTO;
            ivr_pkg::SRC_BRK: a = `IVR_FIX_BRK;
            ivr_pkg::SRC_AMATCH: a = `IVR_FIX_AMATCH;
            ivr_pkg::SRC_SSTEP: a = `IVR_FIX_SSTEP;
            ivr_pkg::SRC_WDT: a = `IVR_FIX_WDT;
            ivr_pkg::SRC_DBC: a = `IVR_FIX_DBC;
            ivr_pkg::SRC_NMI: a = `IVR_FIX_NMI;
            default: a = `IVR_FIX_RESET;
        endcase
        return a;
    endfunction

    logic [63:0] maskable;
    logic bus_req;
    logic bus_wr;
    logic [7:0] widx;
    logic [63:0] hw_clr;
    logic [63:0] sw_clr;
    logic [5:0] sp_set;
    logic [5:0] sp_clr;
    logic [2:0] processor_priority_threshold;
    logic [2:0] best_lvl;
    logic [5:0] best_num;
    logic best_ok;
    logic take;
    logic [19:0] start;
    logic finish;
    logic [15:0] fw;
    logic [31:0] wtmp;

    assign maskable = `IVR_MASKABLE_SET;

    always_comb begin
        s_d = s_q;
        hw_clr = '0;
        sw_clr = '0;
        sp_clr = '0;
        take = 1'b0;
        start = '0;
        finish = 1'b0;
        fw = s_q.processor_flag_word;
        wtmp = '0;
        bus_req = wb_cyc_i && wb_stb_i;
        bus_wr = bus_req && wb_we_i && s_q.ack;
        widx = wb_adr_i[9:2];
        processor_priority_threshold = s_q.processor_flag_word[`IVR_FLG_IPL_LSB +: 3];

        // Classic Wishbone: answer one cycle after the request, drop ack the cycle after.
        s_d.ack = bus_req && !s_q.ack;
        s_d.dat = '0;
        if (bus_req && !s_q.ack && !wb_we_i) begin
            if (widx == `IVR_REG_TABLE_BASE) begin
                s_d.dat = {12'h000, s_q.vector_table_base};
            end else if (widx == `IVR_REG_FLAG_WORD) begin
                s_d.dat = {16'h0000, s_q.processor_flag_word};
            end else if (widx == `IVR_REG_SPECIAL) begin
                s_d.dat = {25'h0000000, s_q.spec_pend, s_q.am_en};
            end else if (widx == `IVR_REG_STATUS) begin
                s_d.dat = {20'h00000, s_q.cur_kind, s_q.cur_num, 1'b0, s_q.st};
            end else if (widx == `IVR_REG_SAVED_FLAG) begin
                s_d.dat = {16'h0000, s_q.saved_flag};
            end else if ((widx & 8'hc0) == `IVR_REG_CTL_FIRST && maskable[widx[5:0]]) begin
                s_d.dat = {28'h0000000, s_q.ctl[widx[5:0]]};
            end
        end

        // Register writes take effect at the edge that drops ack, one cycle after the edge that raises it.
        if (bus_wr) begin
            if (widx == `IVR_REG_TABLE_BASE) begin
                wtmp = merge({12'h000, s_q.vector_table_base}, wb_dat_i, wb_sel_i);
                s_d.vector_table_base = wtmp[19:0];
            end else if (widx == `IVR_REG_FLAG_WORD) begin
                wtmp = merge({16'h0000, s_q.processor_flag_word}, wb_dat_i, wb_sel_i);
                fw = wtmp[15:0];
            end else if (widx == `IVR_REG_SPECIAL && wb_sel_i[0]) begin
                s_d.am_en = wb_dat_i[0];
            end else if ((widx & 8'hc0) == `IVR_REG_CTL_FIRST && maskable[widx[5:0]]
                    && wb_sel_i[0]) begin
                s_d.ctl[widx[5:0]].lvl = wb_dat_i[`IVR_CTL_LVL_LSB +: 3];
                sw_clr[widx[5:0]] = !wb_dat_i[`IVR_CTL_REQ_BIT];
            end
        end

        // Special pending bits: the non-maskable pin and the debugger, watchdog, single-step and address-match sources.
        sp_set = '0;
        sp_set[`IVR_SP_AMATCH] = address_match_i && s_q.am_en;
        sp_set[`IVR_SP_SSTEP] = single_step_i;
        sp_set[`IVR_SP_WDT] = watchdog_i;
        sp_set[`IVR_SP_DBC] = debugger_break_source_i;
        sp_set[`IVR_SP_NMI] = nmi_pin_i;

        if (trap_i.valid && !s_q.trap.valid) begin
            s_d.trap = trap_i;
        end

        // Maskable arbitration: highest level above threshold, lowest number on a tie.
        best_lvl = processor_priority_threshold;
        best_num = '0;
        best_ok = 1'b0;
        for (int n = 0; n < `IVR_NUM_SRC; n++) begin
            if (maskable[n] && s_q.ctl[n].req && s_q.ctl[n].lvl > best_lvl) begin
                best_lvl = s_q.ctl[n].lvl;
                best_num = n[5:0];
                best_ok = 1'b1;
            end
        end
        best_ok = best_ok && s_q.processor_flag_word[`IVR_FLG_I_BIT];

        // Acceptance at an instruction boundary; fixed sources first, in fixed order.
        if (s_q.st == ivr_pkg::ST_IDLE && cpu_ready_i) begin
            take = 1'b1;
            s_d.cur_lvl = `IVR_HW_LEVEL;
            s_d.cur_num = '0;
            if (s_q.spec_pend[`IVR_SP_RESET]) begin
                s_d.cur_kind = ivr_pkg::SRC_RESET;
                sp_clr[`IVR_SP_RESET] = 1'b1;
            end else if (s_q.spec_pend[`IVR_SP_NMI]) begin
                s_d.cur_kind = ivr_pkg::SRC_NMI;
                sp_clr[`IVR_SP_NMI] = 1'b1;
            end else if (s_q.spec_pend[`IVR_SP_DBC]) begin
                s_d.cur_kind = ivr_pkg::SRC_DBC;
                sp_clr[`IVR_SP_DBC] = 1'b1;
            end else if (s_q.spec_pend[`IVR_SP_WDT]) begin
                s_d.cur_kind = ivr_pkg::SRC_WDT;
                sp_clr[`IVR_SP_WDT] = 1'b1;
            end else if (s_q.spec_pend[`IVR_SP_SSTEP]) begin
                s_d.cur_kind = ivr_pkg::SRC_SSTEP;
                sp_clr[`IVR_SP_SSTEP] = 1'b1;
            end else if (s_q.spec_pend[`IVR_SP_AMATCH]) begin
                s_d.cur_kind = ivr_pkg::SRC_AMATCH;
                sp_clr[`IVR_SP_AMATCH] = 1'b1;
            end else if (s_q.trap.valid) begin
                // Instruction traps keep the current threshold.
                s_d.cur_lvl = processor_priority_threshold;
                s_d.cur_num = s_q.trap.number;
                s_d.trap.valid = 1'b0;
                unique case (s_q.trap.kind)
                    ivr_pkg::TRAP_UND: s_d.cur_kind = ivr_pkg::SRC_UND;
                    ivr_pkg::TRAP_INTO: s_d.cur_kind = ivr_pkg::SRC_INTO;
                    ivr_pkg::TRAP_BRK: s_d.cur_kind = ivr_pkg::SRC_BRK;
                    ivr_pkg::TRAP_INT: s_d.cur_kind = ivr_pkg::SRC_SWINT;
                endcase
            end else if (best_ok) begin
                s_d.cur_kind = ivr_pkg::SRC_PERIPH;
                s_d.cur_num = best_num;
                s_d.cur_lvl = best_lvl;
            end else begin
                take = 1'b0;
            end
        end

        if (take) begin
            if (s_d.cur_kind == ivr_pkg::SRC_SWINT || s_d.cur_kind == ivr_pkg::SRC_PERIPH) begin
                start = var_entry(s_q.vector_table_base, s_d.cur_num);
            end else begin
                start = fixed_entry(s_d.cur_kind);
            end
            s_d.st = ivr_pkg::ST_FETCH;
            s_d.redir = 1'b0;
            s_d.cnt = '0;
            s_d.acc = '0;
            s_d.vec.rd = 1'b1;
            s_d.vec.addr = start;
        end

        // Four byte reads, low address first.
        if (s_q.st == ivr_pkg::ST_FETCH && vec_ack_i) begin
            unique case (s_q.cnt)
                2'd0: s_d.acc[7:0] = vec_data_i;
                2'd1: s_d.acc[15:8] = vec_data_i;
                2'd2: s_d.acc[19:16] = vec_data_i[3:0];
                2'd3: s_d.acc = s_q.acc;
            endcase
            if (s_q.cnt == 2'd0 && s_q.cur_kind == ivr_pkg::SRC_BRK && !s_q.redir
                    && vec_data_i == `IVR_ERASED_BYTE) begin
                s_d.redir = 1'b1;
                s_d.vec.addr = var_entry(s_q.vector_table_base, `IVR_BRK_NUM);
            end else if (s_q.cnt == 2'd3) begin
                finish = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 2'd1;
                s_d.vec.addr = s_q.vec.addr + 20'h00001;
            end
        end

        s_d.branch.valid = 1'b0;
        if (finish) begin
            s_d.st = ivr_pkg::ST_IDLE;
            s_d.vec.rd = 1'b0;
            s_d.branch.valid = 1'b1;
            s_d.branch.addr = s_d.acc;
            s_d.branch.kind = s_q.cur_kind;
            s_d.branch.number = s_q.cur_num;
            s_d.branch.level = s_q.cur_lvl;
            s_d.branch.saved_flag = fw;
            s_d.saved_flag = fw;
            fw[`IVR_FLG_I_BIT] = 1'b0;
            fw[`IVR_FLG_D_BIT] = 1'b0;
            if (!(s_q.cur_kind == ivr_pkg::SRC_SWINT && s_q.cur_num >= `IVR_FIRST_NO_STACK_SWAP)) begin
                fw[`IVR_FLG_U_BIT] = 1'b0;
            end
            fw[`IVR_FLG_IPL_LSB +: 3] = s_q.cur_lvl;
            if (s_q.cur_kind == ivr_pkg::SRC_PERIPH) begin
                hw_clr[s_q.cur_num] = 1'b1;
            end
        end
        s_d.processor_flag_word = fw;

        // A new event beats a clear in the same cycle.
        for (int n = 0; n < `IVR_NUM_SRC; n++) begin
            s_d.ctl[n].req = maskable[n] && ((s_q.ctl[n].req && !hw_clr[n] && !sw_clr[n])
                             || src_evt_i[n]);
        end
        s_d.spec_pend = (s_q.spec_pend & ~sp_clr) | sp_set;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.vector_table_base <= `IVR_BASE_RESET;
            s_q.processor_flag_word <= `IVR_FLG_RESET;
            s_q.spec_pend <= `IVR_SP_RESET_VAL;
            s_q.st <= ivr_pkg::ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = s_q.dat;
    assign vec_req_o = s_q.vec;
    assign branch_o = s_q.branch;

endmodule

/* File: dv/ivr_chk.sv */
// Concurrent checks on the vector resolver ports.
// Assumes binding onto the resolver top module, one clock domain.
`timescale 1ns/1ns
module ivr_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [63:0] src_evt_i,
    input wire logic address_match_i,
    input wire logic single_step_i,
    input wire logic watchdog_i,
    input wire logic debugger_break_source_i,
    input wire logic nmi_pin_i,
    input wire ivr_pkg::trap_t trap_i,
    input wire logic cpu_ready_i,
    input wire ivr_pkg::vec_req_t vec_req_o,
    input wire logic [7:0] vec_data_i,
    input wire logic vec_ack_i,
    input wire ivr_pkg::branch_t branch_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [7:0] byte_q [4];
    logic [19:0] start_q;
    logic rd_q;
    // The first address of each fetch tells which table entry was used.
    always_ff @(posedge clk_i) begin
        rd_q <= vec_req_o.rd;
        if (vec_req_o.rd && !rd_q) begin
            start_q <= vec_req_o.addr;
        end
        if (vec_req_o.rd && vec_ack_i) begin
            byte_q[vec_req_o.addr[1:0]] <= vec_data_i;
        end
    end
    function automatic logic [19:0] fixed_of(input logic [3:0] k);
        case (k)
            4'h6: return 20'hfffdc;
            4'h7: return 20'hfffe0;
            4'h8: return 20'hfffe4;
            default: return 20'hffffc - {14'h0, k, 2'h0};
        endcase
    endfunction
    wb_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus access not answered in one cycle");
    wb_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus acknowledge longer than one cycle");
    wb_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside acknowledge");
    byte_order_a: assert property (vec_req_o.rd && vec_ack_i && vec_req_o.addr[1:0] != 2'h3
        && vec_req_o.addr != 20'hfffe4 |=> vec_req_o.rd
        && vec_req_o.addr == $past(vec_req_o.addr) + 20'h1)
        else $error("vector bytes not fetched upward");
    addr_hold_a: assert property (vec_req_o.rd && !vec_ack_i |=> vec_req_o.rd
        && $stable(vec_req_o.addr))
        else $error("vector read changed before acknowledge");
    fetch_end_a: assert property (vec_req_o.rd && vec_ack_i && vec_req_o.addr[1:0] == 2'h3
        |=> branch_o.valid && !vec_req_o.rd)
        else $error("no branch after fourth vector byte");
    branch_pulse_a: assert property (branch_o.valid |=> !branch_o.valid)
        else $error("branch valid longer than one cycle");
    addr_build_a: assert property (branch_o.valid |-> branch_o.addr
        == {byte_q[2][3:0], byte_q[1], byte_q[0]})
        else $error("branch address not built from vector bytes");
    fixed_vec_a: assert property (branch_o.valid && branch_o.kind <= ivr_pkg::SRC_BRK
        |-> start_q == fixed_of(branch_o.kind))
        else $error("fixed source fetched from wrong entry");
    mask_gate_a: assert property (branch_o.valid && branch_o.kind == ivr_pkg::SRC_PERIPH
        |-> branch_o.saved_flag[6] && branch_o.level > branch_o.saved_flag[14:12])
        else $error("maskable source taken while masked");
endmodule
bind interrupt_vector_resolver ivr_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .src_evt_i(src_evt_i), .address_match_i(address_match_i), .single_step_i(single_step_i),
    .watchdog_i(watchdog_i), .debugger_break_source_i(debugger_break_source_i),
    .nmi_pin_i(nmi_pin_i), .trap_i(trap_i), .cpu_ready_i(cpu_ready_i),
    .vec_req_o(vec_req_o), .vec_data_i(vec_data_i), .vec_ack_i(vec_ack_i),
    .branch_o(branch_o));

/* File: dv/ivr_vec_mem.sv */
// Byte-wide vector memory answering the resolver's vector reads.
// Assumes one read request held until acknowledged; answers alternate prompt and slow.
`timescale 1ns/1ns
module ivr_vec_mem (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire ivr_pkg::vec_req_t req_i,
    output logic [7:0] data_o,
    output logic ack_o
);
    logic [1:0] wait_q;
    logic slow_q;
    // Data lines are inverted every cycle between answers, so they show a changing pattern.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            data_o <= 8'h00;
            wait_q <= 2'h0;
            slow_q <= 1'b0;
        end else if (req_i.rd && !ack_o && wait_q == 2'h0) begin
            ack_o <= 1'b1;
            data_o <= (req_i.addr[19:2] == 18'h3fff9) ? 8'hff : req_i.addr[7:0] ^ 8'h5a;
            slow_q <= ~slow_q;
            wait_q <= slow_q ? 2'h0 : 2'h2;
        end else begin
            ack_o <= 1'b0;
            data_o <= ~data_o;
            if (req_i.rd && !ack_o) begin
                wait_q <= wait_q - 2'h1;
            end
        end
    end
endmodule

/* File: dv/tb.sv */
// Self-checking bench of the vector resolver over Wishbone and its source inputs.
// Assumes the vector memory model on the fetch port.
`timescale 1ns/1ns
module tb;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cpu_ready_i, vec_ack_i;
    logic [9:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic [63:0] src_evt_i;
    logic [4:0] spec;
    logic [7:0] vec_data_i;
    ivr_pkg::trap_t trap_i;
    ivr_pkg::vec_req_t vec_req_o;
    ivr_pkg::branch_t branch_o;
    int mismatches = 0;
    int checks_done = 0;
    interrupt_vector_resolver DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .src_evt_i(src_evt_i),
        .address_match_i(spec[0]), .single_step_i(spec[1]), .watchdog_i(spec[2]),
        .debugger_break_source_i(spec[3]), .nmi_pin_i(spec[4]), .trap_i(trap_i),
        .cpu_ready_i(cpu_ready_i), .vec_req_o(vec_req_o), .vec_data_i(vec_data_i),
        .vec_ack_i(vec_ack_i), .branch_o(branch_o));
    ivr_vec_mem mem (.clk_i(clk_i), .rst_i(rst_i), .req_i(vec_req_o), .data_o(vec_data_i),
        .ack_o(vec_ack_i));
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [9:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            mismatches++;
            finish_test();
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        check(q, exp);
    endtask
    // Expected routine address from the byte pattern the memory model holds.
    function automatic logic [19:0] vaddr(input logic [19:0] a);
        logic [7:0] b0, b1, b2;
        b0 = a[7:0] ^ 8'h5a;
        b1 = (a[7:0] + 8'h1) ^ 8'h5a;
        b2 = (a[7:0] + 8'h2) ^ 8'h5a;
        return {b2[3:0], b1, b0};
    endfunction
    task automatic expect_branch(input logic [19:0] a, input logic [3:0] k, input logic [5:0] n);
        int i;
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (branch_o.valid !== 1'b1 && i < 200);
        if (i >= 200) begin
            mismatches++;
            finish_test();
        end
        check(32'(branch_o.addr), 32'(vaddr(a)));
        check(32'(branch_o.kind), 32'(k));
        if (k >= 4'h9) begin
            check(32'(branch_o.number), 32'(n));
        end
    endtask
    task automatic no_branch();
        logic seen;
        seen = 1'b0;
        repeat (20) begin
            @(posedge clk_i);
            if (branch_o.valid !== 1'b0) begin
                seen = 1'b1;
            end
        end
        check(32'(seen), 32'h0);
    endtask
    task automatic pulse(input logic [63:0] e);
        @(posedge clk_i);
        src_evt_i <= e;
        @(posedge clk_i);
        src_evt_i <= 64'h0;
    endtask
    task automatic trap(input logic [1:0] k, input logic [5:0] n);
        @(posedge clk_i);
        trap_i <= {1'b1, k, n};
        @(posedge clk_i);
        trap_i <= '0;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    initial begin
        rst_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, spec, src_evt_i} = '0;
        wb_sel_i = 4'hf;
        trap_i = '0;
        cpu_ready_i = 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        expect_branch(20'hffffc, 4'h0, 6'h0);
        rd_chk(10'h004, 32'h7000);
        rd_chk(10'h3fc, 32'h0);
        wb(1'b1, 10'h000, 32'h12300);
        wb(1'b1, 10'h004, 32'h2040);
        wb(1'b1, 10'h128, 32'h3);
        wb(1'b1, 10'h12c, 32'h2);
        pulse(64'h0c00);
        expect_branch(20'h12328, 4'ha, 6'd10);
        check(32'(branch_o.saved_flag), 32'h2040);
        rd_chk(10'h004, 32'h3000);
        rd_chk(10'h128, 32'h3);
        rd_chk(10'h228, 32'h0);
        rd_chk(10'h12c, 32'ha);
        wb(1'b1, 10'h130, 32'h2);
        pulse(64'h1000);
        wb(1'b1, 10'h004, 32'h0040);
        expect_branch(20'h1232c, 4'ha, 6'd11);
        wb(1'b1, 10'h130, 32'h0);
        rd_chk(10'h130, 32'h0);
        wb(1'b1, 10'h004, 32'h0040);
        pulse(64'h2000);
        no_branch();
        rd_chk(10'h134, 32'h8);
        wb(1'b1, 10'h004, 32'h0);
        spec <= 5'h01;
        no_branch();
        spec <= 5'h0;
        wb(1'b1, 10'h008, 32'h1);
        for (int i = 0; i < 5; i++) begin
            @(posedge clk_i);
            spec <= 5'(1 << i);
            @(posedge clk_i);
            spec <= 5'h0;
            expect_branch(20'hfffe8 + 20'(4 * i), 4'(5 - i), 6'h0);
        end
        for (int j = 0; j < 2; j++) begin
            trap(2'(j), 6'h0);
            expect_branch(20'hfffdc + 20'(4 * j), 4'(6 + j), 6'h0);
        end
        trap(2'h2, 6'h0);
        expect_branch(20'h12300, 4'h8, 6'h0);
        trap(2'h3, 6'd60);
        expect_branch(20'h123f0, 4'h9, 6'd60);
        finish_test();
    end
endmodule
